/* File: rtl/bwt_top.sv */
// Branch and window trace unit with port serializer and branch buffer
//
// Behaviour
// - With port branch trace on, every taken branch sends its source and target address.
// - Two window channels A and B capture accesses whose address lies in their range.
// - Each window channel qualifies reads, writes or both by its cycle type bits.
// - Each window channel has its own enable and captures nothing while it is clear.
// - With software trace on, a trace instruction with no traced branch in the same cycle sends its program counter and one register.
// - Branch sources are sent as 16, 8 or 4 low bits when the upper bits match the last one.
// - Window addresses are compressed the same way against the last window address sent.
// - The internal buffer keeps source and target of the latest eight qualifying branches.
// - The normal class enable qualifies conditional, relative, register and indirect jumps.
// - The subroutine class enable qualifies all calls and subroutine returns.
// - The exception class enable qualifies exception returns and exception entries.
// - Continuous mode lets the buffer be filled and drained up to four times per session.
// - Continuous mode stalls the processor while a full buffer waits to be drained.
// - A record arriving while the port is busy stalls the processor, or is dropped in realtime.
`timescale 1ns/1ns
`default_nettype none
module bwt_top (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire bwt_pkg::bwt_br_t BR_EVT,
   input wire bwt_pkg::bwt_mem_t MEM_EVT,
   input wire bwt_pkg::bwt_sw_t SW_EVT,
   input wire logic TRACE_CLK,
   output logic [3:0] TRACE_DATA,
   output logic TRACE_SYNC_N,
   output logic CPU_STALL
);

   // ************
   // Functions
   // ************
   function automatic logic [1:0] size_of(input logic [31:0] a, input logic [31:0] r,
                                          input logic v);
      logic [1:0] s;
      s = bwt_pkg::SZ_32;
      if (v && a[31:4] == r[31:4]) begin
         s = bwt_pkg::SZ_4;
      end else if (v && a[31:8] == r[31:8]) begin
         s = bwt_pkg::SZ_8;
      end else if (v && a[31:16] == r[31:16]) begin
         s = bwt_pkg::SZ_16;
      end
      return s;
   endfunction : size_of

   function automatic bwt_pkg::bwt_rec_t mk_rec(input logic [1:0] ht, input logic [1:0] sz,
                                                input logic [31:0] a, input logic [31:0] b,
                                                input logic two);
      bwt_pkg::bwt_rec_t r;
      logic [3:0] n;
      logic [31:0] m;
      n = 4'h8;
      m = 32'hffff_ffff;
      case (sz)
         bwt_pkg::SZ_4: begin
            n = 4'h1;
            m = 32'h0000_000f;
         end
         bwt_pkg::SZ_8: begin
            n = 4'h2;
            m = 32'h0000_00ff;
         end
         bwt_pkg::SZ_16: begin
            n = 4'h4;
            m = 32'h0000_ffff;
         end
         default: begin
            n = 4'h8;
            m = 32'hffff_ffff;
         end
      endcase
      r.nib = {64'h0, ht, sz} | ({36'h0, a & m} << 4);
      if (two) begin
         r.nib = r.nib | ({36'h0, b} << (4 + 4 * n));
      end
      r.cnt = 5'h1 + {1'b0, n} + (two ? 5'h8 : 5'h0);
      return r;
   endfunction : mk_rec

   function automatic bwt_pkg::bwt_class_t kind_class(input bwt_pkg::bwt_kind_t k);
      case (k)
         bwt_pkg::K_BRANCH_IF_FALSE, bwt_pkg::K_DELAYED_BRANCH_IF_FALSE,
         bwt_pkg::K_DELAYED_BRANCH_IF_TRUE, bwt_pkg::K_RELATIVE_BRANCH,
         bwt_pkg::K_REGISTER_RELATIVE_BRANCH,
         bwt_pkg::K_REGISTER_INDIRECT_JUMP: return bwt_pkg::CLS_NORMAL;
         bwt_pkg::K_RELATIVE_CALL, bwt_pkg::K_REGISTER_RELATIVE_CALL,
         bwt_pkg::K_REGISTER_INDIRECT_CALL,
         bwt_pkg::K_SUBROUTINE_RETURN: return bwt_pkg::CLS_SUB;
         bwt_pkg::K_EXCEPTION_RETURN, bwt_pkg::K_EXCEPTION_ENTRY: return bwt_pkg::CLS_EXC;
         default: return bwt_pkg::CLS_NONE;
      endcase
   endfunction : kind_class

   function automatic logic win_hit(input logic en, input logic [31:0] lo, input logic [31:0] hi,
                                    input logic [1:0] cyc, input bwt_pkg::bwt_mem_t m);
      return en && m.vld && m.addr >= lo && m.addr <= hi
             && (m.write ? cyc[1] : cyc[0]);
   endfunction : win_hit

   // ************
   // Registers
   // ************
   logic [8:0] ctrl_r;
   logic [31:0] wa_lo_r, wa_hi_r, wb_lo_r, wb_hi_r;
   logic [3:0] wcyc_r;
   logic [2:0] bsel_r;
   logic [31:0] buf_src [bwt_pkg::BUF_DEPTH];
   logic [31:0] buf_dst [bwt_pkg::BUF_DEPTH];
   logic [2:0] wptr_r;
   logic [3:0] bcnt_r;
   logic [2:0] fills_r;
   logic full_r;
   logic [31:0] br_ref_r, win_ref_r;
   logic br_ref_vld_r, win_ref_vld_r;
   logic tck_s1_r, tck_s2_r, tck_s3_r, tck_lvl_r;
   bwt_pkg::bwt_state_t st_r;
   logic [67:0] sh_r;
   logic [4:0] cnt_r;
   logic first_r;
   bwt_pkg::bwt_rec_t pend_r;
   logic pend_vld_r;
   logic pready_r, pslverr_r, stall_r, sync_n_r;
   logic [31:0] prdata_r;
   logic [3:0] data_r;

   // ************
   // Combinational decode
   // ************
   logic tck_rise, apb_acc, apb_done, mapped, wr_ctrl, wr_ack, buf_take, last_nib;
   logic accept_now, accept_pend, cand_vld, upd_br, upd_win, pend_vld_nxt;
   logic wa_hit, wb_hit;
   bwt_pkg::bwt_rec_t cand;
   logic [31:0] rd_mux;
   bwt_pkg::bwt_class_t br_cls;

   assign tck_rise = tck_s2_r == tck_s3_r && tck_s2_r && !tck_lvl_r;
   assign apb_acc = PSEL && PENABLE && !pready_r;
   assign apb_done = PSEL && PENABLE && pready_r && PWRITE && mapped;
   assign wr_ctrl = apb_done && PADDR == bwt_pkg::REG_CTRL;
   assign wr_ack = apb_done && PADDR == bwt_pkg::REG_BSTAT && PWDATA[0];
   assign wa_hit = win_hit(ctrl_r[bwt_pkg::CTL_WA], wa_lo_r, wa_hi_r, wcyc_r[1:0], MEM_EVT);
   assign wb_hit = win_hit(ctrl_r[bwt_pkg::CTL_WB], wb_lo_r, wb_hi_r, wcyc_r[3:2], MEM_EVT);
   assign br_cls = kind_class(BR_EVT.kind);
   assign last_nib = st_r == bwt_pkg::S_SEND && tck_rise && cnt_r == 5'h1;

   always_comb begin
      cand = '0;
      cand_vld = 1'b0;
      upd_br = 1'b0;
      upd_win = 1'b0;
      if (ctrl_r[bwt_pkg::CTL_BR] && BR_EVT.vld) begin
         cand = mk_rec(bwt_pkg::HT_BR, size_of(BR_EVT.src, br_ref_r, br_ref_vld_r),
                       BR_EVT.src, BR_EVT.dst, 1'b1);
         cand_vld = 1'b1;
         upd_br = 1'b1;
      end else if (ctrl_r[bwt_pkg::CTL_SW] && SW_EVT.vld) begin
         cand = mk_rec(bwt_pkg::HT_SW, bwt_pkg::SZ_32, SW_EVT.pc, SW_EVT.gpr, 1'b1);
         cand_vld = 1'b1;
      end else if (wa_hit || wb_hit) begin
         cand = mk_rec(wa_hit ? bwt_pkg::HT_WA : bwt_pkg::HT_WB,
                       size_of(MEM_EVT.addr, win_ref_r, win_ref_vld_r),
                       MEM_EVT.addr, 32'h0, 1'b0);
         cand_vld = 1'b1;
         upd_win = 1'b1;
      end
   end

   assign accept_now = cand_vld && st_r == bwt_pkg::S_IDLE && !pend_vld_r;
   assign accept_pend = cand_vld && st_r == bwt_pkg::S_SEND && !pend_vld_r
                        && !ctrl_r[bwt_pkg::CTL_RT];
   assign pend_vld_nxt = accept_pend || (pend_vld_r && !last_nib && st_r == bwt_pkg::S_SEND);

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0;
      case (PADDR)
         bwt_pkg::REG_CTRL: rd_mux = {23'h0, ctrl_r};
         bwt_pkg::REG_WA_LO: rd_mux = wa_lo_r;
         bwt_pkg::REG_WA_HI: rd_mux = wa_hi_r;
         bwt_pkg::REG_WB_LO: rd_mux = wb_lo_r;
         bwt_pkg::REG_WB_HI: rd_mux = wb_hi_r;
         bwt_pkg::REG_WCYC: rd_mux = {28'h0, wcyc_r};
         bwt_pkg::REG_BSTAT: begin
            rd_mux[2:0] = wptr_r;
            rd_mux[bwt_pkg::ST_CNT +: 4] = bcnt_r;
            rd_mux[bwt_pkg::ST_FILL +: 3] = fills_r;
            rd_mux[bwt_pkg::ST_FULL] = full_r;
            rd_mux[bwt_pkg::ST_PEND] = pend_vld_r;
            rd_mux[bwt_pkg::ST_BUSY] = st_r == bwt_pkg::S_SEND;
         end
         bwt_pkg::REG_BSEL: rd_mux = {29'h0, bsel_r};
         bwt_pkg::REG_BSRC: rd_mux = buf_src[bsel_r];
         bwt_pkg::REG_BDST: rd_mux = buf_dst[bsel_r];
         default: mapped = 1'b0;
      endcase
   end

   // ************
   // APB slave
   // ************
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= apb_acc;
         pslverr_r <= apb_acc && !mapped;
         prdata_r <= (apb_acc && !PWRITE) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ctrl_r <= bwt_pkg::CTRL_RST;
         wa_lo_r <= bwt_pkg::WIN_RST;
         wa_hi_r <= bwt_pkg::WIN_RST;
         wb_lo_r <= bwt_pkg::WIN_RST;
         wb_hi_r <= bwt_pkg::WIN_RST;
         wcyc_r <= bwt_pkg::WCYC_RST;
         bsel_r <= 3'h0;
      end else if (apb_done) begin
         case (PADDR)
            bwt_pkg::REG_CTRL: ctrl_r <= PWDATA[8:0];
            bwt_pkg::REG_WA_LO: wa_lo_r <= PWDATA;
            bwt_pkg::REG_WA_HI: wa_hi_r <= PWDATA;
            bwt_pkg::REG_WB_LO: wb_lo_r <= PWDATA;
            bwt_pkg::REG_WB_HI: wb_hi_r <= PWDATA;
            bwt_pkg::REG_WCYC: wcyc_r <= PWDATA[3:0];
            bwt_pkg::REG_BSEL: bsel_r <= PWDATA[2:0];
            default: ;
         endcase
      end
   end

   // ************
   // Trace clock synchroniser
   // ************
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         tck_s1_r <= 1'b0;
         tck_s2_r <= 1'b0;
         tck_s3_r <= 1'b0;
         tck_lvl_r <= 1'b0;
      end else begin
         tck_s1_r <= TRACE_CLK;
         tck_s2_r <= tck_s1_r;
         tck_s3_r <= tck_s2_r;
         if (tck_s2_r == tck_s3_r) begin
            tck_lvl_r <= tck_s3_r;
         end
      end
   end

   // ************
   // Compression references
   // ************
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         br_ref_r <= 32'h0;
         win_ref_r <= 32'h0;
         br_ref_vld_r <= 1'b0;
         win_ref_vld_r <= 1'b0;
      end else if (accept_now || accept_pend) begin
         if (upd_br) begin
            br_ref_r <= BR_EVT.src;
            br_ref_vld_r <= 1'b1;
         end
         if (upd_win) begin
            win_ref_r <= MEM_EVT.addr;
            win_ref_vld_r <= 1'b1;
         end
      end
   end

   // ************
   // Port serializer
   // ************
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         pend_r <= '0;
         pend_vld_r <= 1'b0;
      end else begin
         pend_vld_r <= pend_vld_nxt;
         if (accept_pend) begin
            pend_r <= cand;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         st_r <= bwt_pkg::S_IDLE;
         sh_r <= 68'h0;
         cnt_r <= 5'h0;
         first_r <= 1'b0;
         data_r <= 4'h0;
         sync_n_r <= 1'b1;
      end else begin
         case (st_r)
            bwt_pkg::S_IDLE: begin
               if (tck_rise) begin
                  data_r <= 4'h0;
                  sync_n_r <= 1'b1;
               end
               if (accept_now || pend_vld_r) begin
                  st_r <= bwt_pkg::S_SEND;
                  sh_r <= pend_vld_r ? pend_r.nib : cand.nib;
                  cnt_r <= pend_vld_r ? pend_r.cnt : cand.cnt;
                  first_r <= 1'b1;
               end
            end
            bwt_pkg::S_SEND: begin
               if (tck_rise) begin
                  data_r <= sh_r[3:0];
                  sync_n_r <= !first_r;
                  sh_r <= sh_r >> 4;
                  cnt_r <= cnt_r - 5'h1;
                  first_r <= 1'b0;
                  if (last_nib && pend_vld_r) begin
                     sh_r <= pend_r.nib;
                     cnt_r <= pend_r.cnt;
                     first_r <= 1'b1;
                  end else if (last_nib) begin
                     st_r <= bwt_pkg::S_IDLE;
                  end
               end
            end
            default: st_r <= bwt_pkg::S_IDLE;
         endcase
      end
   end

   // ************
   // Internal branch buffer
   // ************
   assign buf_take = BR_EVT.vld && !full_r && fills_r < bwt_pkg::FILL_MAX
                     && ((br_cls == bwt_pkg::CLS_NORMAL && ctrl_r[bwt_pkg::CTL_NRM])
                     || (br_cls == bwt_pkg::CLS_SUB && ctrl_r[bwt_pkg::CTL_SUB])
                     || (br_cls == bwt_pkg::CLS_EXC && ctrl_r[bwt_pkg::CTL_EXC]));

   always_ff @(posedge CORE_CLK) begin
      if (buf_take) begin
         buf_src[wptr_r] <= BR_EVT.src;
         buf_dst[wptr_r] <= BR_EVT.dst;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         wptr_r <= 3'h0;
         bcnt_r <= 4'h0;
         fills_r <= 3'h0;
         full_r <= 1'b0;
      end else if (wr_ctrl) begin
         wptr_r <= 3'h0;
         bcnt_r <= 4'h0;
         fills_r <= 3'h0;
         full_r <= 1'b0;
      end else if (wr_ack && full_r) begin
         wptr_r <= 3'h0;
         bcnt_r <= 4'h0;
         full_r <= 1'b0;
      end else if (buf_take) begin
         wptr_r <= wptr_r + 3'h1;
         if (bcnt_r != 4'h8) begin
            bcnt_r <= bcnt_r + 4'h1;
         end
         if (ctrl_r[bwt_pkg::CTL_CONT] && bcnt_r == 4'h7) begin
            full_r <= 1'b1;
            fills_r <= fills_r + 3'h1;
         end
      end
   end

   // ************
   // Processor stall and outputs
   // ************
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         stall_r <= 1'b0;
      end else begin
         stall_r <= pend_vld_nxt
                    || (ctrl_r[bwt_pkg::CTL_CONT] && full_r && !wr_ack && !wr_ctrl);
      end
   end

   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign TRACE_DATA = data_r;
   assign TRACE_SYNC_N = sync_n_r;
   assign CPU_STALL = stall_r;

endmodule : bwt_top
`default_nettype wire

/* File: rtl/bwt_pkg.sv */
// Constants and types of the branch and window trace unit
package bwt_pkg;

   // ************
   // Register map
   // ************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_WA_LO = 8'h04;
   localparam logic [7:0] REG_WA_HI = 8'h08;
   localparam logic [7:0] REG_WB_LO = 8'h0c;
   localparam logic [7:0] REG_WB_HI = 8'h10;
   localparam logic [7:0] REG_WCYC = 8'h14;
   localparam logic [7:0] REG_BSTAT = 8'h18;
   localparam logic [7:0] REG_BSEL = 8'h1c;
   localparam logic [7:0] REG_BSRC = 8'h20;
   localparam logic [7:0] REG_BDST = 8'h24;

   // ************
   // Field positions and reset values
   // ************
   localparam int CTL_BR = 0;
   localparam int CTL_WA = 1;
   localparam int CTL_WB = 2;
   localparam int CTL_SW = 3;
   localparam int CTL_RT = 4;
   localparam int CTL_NRM = 5;
   localparam int CTL_SUB = 6;
   localparam int CTL_EXC = 7;
   localparam int CTL_CONT = 8;
   localparam int ST_CNT = 4;
   localparam int ST_FILL = 8;
   localparam int ST_FULL = 12;
   localparam int ST_PEND = 16;
   localparam int ST_BUSY = 17;
   localparam logic [8:0] CTRL_RST = 9'h000;
   localparam logic [3:0] WCYC_RST = 4'hf;
   localparam logic [31:0] WIN_RST = 32'h0000_0000;

   // ************
   // Buffer and record sizes
   // ************
   localparam int BUF_DEPTH = 8;
   localparam logic [2:0] FILL_MAX = 3'h4;
   localparam logic [1:0] SZ_4 = 2'h0;
   localparam logic [1:0] SZ_8 = 2'h1;
   localparam logic [1:0] SZ_16 = 2'h2;
   localparam logic [1:0] SZ_32 = 2'h3;
   localparam logic [1:0] HT_BR = 2'h0;
   localparam logic [1:0] HT_WA = 2'h1;
   localparam logic [1:0] HT_WB = 2'h2;
   localparam logic [1:0] HT_SW = 2'h3;

   // ************
   // Types
   // ************
   typedef enum logic [3:0] {
      K_BRANCH_IF_FALSE = 4'h0, K_DELAYED_BRANCH_IF_FALSE = 4'h1,
      K_DELAYED_BRANCH_IF_TRUE = 4'h2, K_RELATIVE_BRANCH = 4'h3,
      K_REGISTER_RELATIVE_BRANCH = 4'h4, K_REGISTER_INDIRECT_JUMP = 4'h5,
      K_RELATIVE_CALL = 4'h6, K_REGISTER_RELATIVE_CALL = 4'h7,
      K_REGISTER_INDIRECT_CALL = 4'h8, K_SUBROUTINE_RETURN = 4'h9,
      K_EXCEPTION_RETURN = 4'ha, K_EXCEPTION_ENTRY = 4'hb, K_OTHER = 4'hf
   } bwt_kind_t;
   typedef enum logic [1:0] {CLS_NONE, CLS_NORMAL, CLS_SUB, CLS_EXC} bwt_class_t;
   typedef enum logic {S_IDLE = 1'b0, S_SEND = 1'b1} bwt_state_t;
   typedef struct packed {logic vld; bwt_kind_t kind;
      logic [31:0] src; logic [31:0] dst;} bwt_br_t;
   typedef struct packed {logic vld; logic write; logic [31:0] addr;} bwt_mem_t;
   typedef struct packed {logic vld; logic [31:0] pc; logic [31:0] gpr;} bwt_sw_t;
   typedef struct packed {logic [67:0] nib; logic [4:0] cnt;} bwt_rec_t;

endpackage : bwt_pkg

/* File: test/bwt_top_asserts.sv */
// Port checks for the trace unit
`timescale 1ns/1ns
`default_nettype none
module bwt_top_asserts (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire bwt_pkg::bwt_br_t BR_EVT,
   input wire bwt_pkg::bwt_mem_t MEM_EVT,
   input wire bwt_pkg::bwt_sw_t SW_EVT,
   input wire logic TRACE_CLK,
   input wire logic [3:0] TRACE_DATA,
   input wire logic TRACE_SYNC_N,
   input wire logic CPU_STALL
);
   // ************
   // Helper state
   // ************
   logic [8:0] ctl_r;
   logic first_r;
   logic [8:0] quiet_r;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ctl_r <= 9'h000;
      end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == bwt_pkg::REG_CTRL) begin
         ctl_r <= PWDATA[8:0];
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         first_r <= 1'b1;
      end else if (!TRACE_SYNC_N) begin
         first_r <= 1'b0;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N || ctl_r[3:0] != 4'h0) begin
         quiet_r <= 9'h000;
      end else if (quiet_r != 9'h040) begin
         quiet_r <= quiet_r + 9'h001;
      end
   end
   // ************
   // Assertions
   // ************
   AST_APB_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("No answer after one wait");
   AST_ERR_READY: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
      else $error("Error flag outside an answer");
   AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
      else $error("Read data not zero when idle");
   AST_RST_OUT: assert property ($rose(RST_N) |-> TRACE_SYNC_N && !CPU_STALL && !PREADY)
      else $error("Outputs not at reset level");
   AST_BR_SENT: assert property (BR_EVT.vld && ctl_r[0] && !ctl_r[4]
      |-> ##[1:600] !TRACE_SYNC_N)
      else $error("Branch gave no record");
   AST_WIN_QUIET: assert property (quiet_r == 9'h040 |-> TRACE_SYNC_N)
      else $error("Record with sources off");
   AST_SW_SENT: assert property (SW_EVT.vld && ctl_r[3] && !BR_EVT.vld
      |-> ##[1:600] (!TRACE_SYNC_N && TRACE_DATA[3:2] == bwt_pkg::HT_SW))
      else $error("Software event gave no record");
   AST_STALL_PEND: assert property (BR_EVT.vld && $past(BR_EVT.vld)
      && ctl_r[0] && !ctl_r[4] |-> ##[1:3] CPU_STALL)
      else $error("No stall for a held record");
   AST_RT_NOSTALL: assert property (BR_EVT.vld && $past(BR_EVT.vld) && ctl_r[0]
      && ctl_r[4] && ctl_r[8:5] == 4'h0 |=> !CPU_STALL [*3])
      else $error("Stall in realtime mode");
   AST_FIRST_FULL: assert property (!TRACE_SYNC_N && first_r |-> TRACE_DATA[1:0] == bwt_pkg::SZ_32)
      else $error("First record not full");
endmodule : bwt_top_asserts
`default_nettype wire

/* File: test/bwt_emu.sv */
// Trace port receiver model
`timescale 1ns/1ns
`default_nettype none
module bwt_emu (
   input wire logic run,
   output logic trace_clk,
   input wire logic [3:0] trace_data,
   input wire logic trace_sync_n
);
   logic [31:0] ref_br, ref_win, fa, fb;
   logic [3:0] hdr;
   int na, left, pos;
   logic [3:0] rec_h[$];
   logic [31:0] rec_a[$];
   logic [31:0] rec_b[$];
   // ************
   // Link clock, still while not running
   // ************
   initial begin
      trace_clk = 1'b0;
      #7;
      forever begin
         #160;
         trace_clk = run ? ~trace_clk : 1'b0;
      end
   end
   // ************
   // Record capture
   // ************
   always @(posedge trace_clk) begin
      if (!trace_sync_n) begin
         hdr = trace_data;
         na = 1 << hdr[1:0];
         left = na + ((hdr[3:2] == 2'h0 || hdr[3:2] == 2'h3) ? 8 : 0);
         pos = 0;
         fb = 32'h0;
         fa = hdr[3:2] == 2'h0 ? ref_br : (hdr[3:2] == 2'h3 ? 32'h0 : ref_win);
      end else if (left > 0) begin
         if (pos < na) begin
            fa[pos*4 +: 4] = trace_data;
         end else begin
            fb[(pos-na)*4 +: 4] = trace_data;
         end
         pos = pos + 1;
         left = left - 1;
         if (left == 0 && rec_h.size() < 256) begin
            if (hdr[3:2] == 2'h0) ref_br = fa;
            else if (hdr[3:2] != 2'h3) ref_win = fa;
            rec_h.push_back(hdr);
            rec_a.push_back(fa);
            rec_b.push_back(fb);
         end
      end
   end
endmodule : bwt_emu
`default_nettype wire

/* File: test/bwt_top_tb_top.sv */
// Testbench for the trace unit
`timescale 1ns/1ns
`default_nettype none
module bwt_top_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic run = 1'b0;
   bwt_pkg::bwt_br_t be = '0;
   bwt_pkg::bwt_mem_t me = '0;
   bwt_pkg::bwt_sw_t se = '0;
   logic pready, pslverr, tclk, sync_n, stall, err;
   logic [31:0] prdata, q;
   logic [3:0] tdata;
   int error_cnt = 0;
   int num_checks = 0;
   int n = 0;
   logic [31:0] srcs[4] = '{32'h1234_5678, 32'h1234_abcd, 32'h1234_ab00, 32'h1234_ab0f};
   logic [3:0] ek[4] = '{4'h9, 4'ha, 4'h5, 4'hb};
   always #20 clk = ~clk;
   bwt_top u_dut (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .BR_EVT(be), .MEM_EVT(me), .SW_EVT(se), .TRACE_CLK(tclk),
      .TRACE_DATA(tdata), .TRACE_SYNC_N(sync_n), .CPU_STALL(stall));
   bwt_emu u_emu (.run(run), .trace_clk(tclk), .trace_data(tdata), .trace_sync_n(sync_n));
   // ************
   // Tasks
   // ************
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tmo(input int k);
      if (k >= 3000) begin
         error_cnt++;
         $display("[ERR] wait expected done seen limit");
         final_report();
      end
   endtask : tmo
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 3000);
      tmo(k);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, q & m);
   endtask : rc
   task automatic ev(input bwt_pkg::bwt_br_t b, input bwt_pkg::bwt_mem_t m,
                     input bwt_pkg::bwt_sw_t s);
      int k;
      k = 0;
      while (stall !== 1'b0 && k < 3000) begin
         @(posedge clk);
         k++;
      end
      tmo(k);
      be <= b;
      me <= m;
      se <= s;
      @(posedge clk);
      be.vld <= 1'b0;
      me.vld <= 1'b0;
      se.vld <= 1'b0;
      @(posedge clk);
   endtask : ev
   task automatic br(input logic [3:0] k, input logic [31:0] s, input logic [31:0] d);
      ev('{1'b1, bwt_pkg::bwt_kind_t'(k), s, d}, '0, '0);
   endtask : br
   task automatic mem(input logic w, input logic [31:0] a);
      ev('0, '{1'b1, w, a}, '0);
   endtask : mem
   task automatic got(input int i, input logic [3:0] h, input logic [31:0] a,
                      input logic [31:0] b);
      int k;
      k = 0;
      while (u_emu.rec_h.size() <= i && k < 3000) begin
         @(posedge clk);
         k++;
      end
      tmo(k);
      chk("header", {28'h0, h}, {28'h0, u_emu.rec_h[i]});
      chk("first field", a, u_emu.rec_a[i]);
      chk("second field", b, u_emu.rec_b[i]);
   endtask : got
   // ************
   // Sequence
   // ************
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rc("ctrl", bwt_pkg::REG_CTRL, 32'hffff_ffff, 32'h0);
      rc("wcyc", bwt_pkg::REG_WCYC, 32'hffff_ffff, 32'hf);
      rc("unmapped", 8'h40, 32'hffff_ffff, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      run <= 1'b1;
      apb(1'b1, bwt_pkg::REG_CTRL, 32'h1);
      for (int i = 0; i < 4; i++) begin
         br(4'h3, srcs[i], 32'h8000_0000 + i);
         got(n, {bwt_pkg::HT_BR, 2'(3 - i)}, srcs[i], 32'h8000_0000 + i);
         n++;
      end
      apb(1'b1, bwt_pkg::REG_WA_LO, 32'h0000_1000);
      apb(1'b1, bwt_pkg::REG_WA_HI, 32'h0000_10ff);
      apb(1'b1, bwt_pkg::REG_WB_LO, 32'h0000_2000);
      apb(1'b1, bwt_pkg::REG_WB_HI, 32'h0000_20ff);
      apb(1'b1, bwt_pkg::REG_WCYC, 32'h9);
      apb(1'b1, bwt_pkg::REG_CTRL, 32'h2);
      mem(1'b1, 32'h0000_1010);
      mem(1'b0, 32'h0000_0fff);
      mem(1'b0, 32'h0000_1100);
      mem(1'b1, 32'h0000_2004);
      mem(1'b0, 32'h0000_10f0);
      got(n, {bwt_pkg::HT_WA, bwt_pkg::SZ_32}, 32'h0000_10f0, 32'h0);
      apb(1'b1, bwt_pkg::REG_CTRL, 32'h6);
      mem(1'b0, 32'h0000_2008);
      mem(1'b1, 32'h0000_20f8);
      got(n + 1, {bwt_pkg::HT_WB, bwt_pkg::SZ_16}, 32'h0000_20f8, 32'h0);
      apb(1'b1, bwt_pkg::REG_CTRL, 32'h8);
      ev('0, '0, '{1'b1, 32'h0000_4abc, 32'h5a5a_0f0f});
      got(n + 2, {bwt_pkg::HT_SW, bwt_pkg::SZ_32}, 32'h0000_4abc, 32'h5a5a_0f0f);
      n += 3;
      for (int r = 0; r < 2; r++) begin
         apb(1'b1, bwt_pkg::REG_CTRL, r == 1 ? 32'h11 : 32'h1);
         be <= '{1'b1, bwt_pkg::K_RELATIVE_BRANCH, 32'h1234_ab10, 32'h0};
         @(posedge clk);
         be <= '{1'b1, bwt_pkg::K_RELATIVE_BRANCH, 32'h1234_ab20, 32'h1};
         @(posedge clk);
         be.vld <= 1'b0;
         repeat (2) @(posedge clk);
         chk("stall", 32'(r == 0), {31'h0, stall});
         got(n, {bwt_pkg::HT_BR, bwt_pkg::SZ_8}, 32'h1234_ab10, 32'h0);
         if (r == 1) br(4'h3, 32'h1234_ab20, 32'h2);
         got(n + 1, {bwt_pkg::HT_BR, bwt_pkg::SZ_8}, 32'h1234_ab20, 32'(r + 1));
         n += 2;
      end
      run <= 1'b0;
      apb(1'b1, bwt_pkg::REG_CTRL, 32'h60);
      for (int k = 0; k < 13; k++) br(k < 12 ? 4'(k) : 4'hf, 32'(k), ~32'(k));
      rc("buffer state", bwt_pkg::REG_BSTAT, 32'hff, 32'h82);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, bwt_pkg::REG_BSEL, 32'(i));
         rc("entry source", bwt_pkg::REG_BSRC, 32'hffff_ffff, 32'(i < 2 ? i + 8 : i));
         rc("entry target", bwt_pkg::REG_BDST, 32'hffff_ffff, ~32'(i < 2 ? i + 8 : i));
      end
      apb(1'b1, bwt_pkg::REG_CTRL, 32'h80);
      for (int k = 0; k < 4; k++) br(ek[k], 32'(ek[k]), 32'h0);
      rc("buffer state", bwt_pkg::REG_BSTAT, 32'hff, 32'h22);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, bwt_pkg::REG_BSEL, 32'(i));
         rc("entry source", bwt_pkg::REG_BSRC, 32'hffff_ffff, 32'ha + i);
      end
      apb(1'b1, bwt_pkg::REG_CTRL, 32'h120);
      for (int f = 1; f <= 5; f++) begin
         for (int k = 0; k < 8; k++) br(4'h3, 32'(k), 32'h0);
         rc("fill state", bwt_pkg::REG_BSTAT, 32'h17f0,
            f < 5 ? 32'h1080 | (f << 8) : 32'h0400);
         chk("stall", 32'(f < 5), {31'h0, stall});
         apb(1'b1, bwt_pkg::REG_BSTAT, 32'h1);
      end
      final_report();
   end
endmodule : bwt_top_tb_top
bind bwt_top bwt_top_asserts u_chk (.CORE_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
   .PWDATA, .PRDATA, .PREADY, .PSLVERR, .BR_EVT, .MEM_EVT, .SW_EVT, .TRACE_CLK, .TRACE_DATA,
   .TRACE_SYNC_N, .CPU_STALL);
`default_nettype wire
